// File: core/ecg_threshold_core.sv
// range, lead-off and pace limits plus channel word packing
// assumes decoded register strobes from the serial port, one sample per beat
`timescale 1ns/100ps
`include "ecg_consts.svh"
module ecg_threshold_core
  import ecg_pkg::*;
#(
  parameter int NCHAN = 5,
  parameter int NPACE = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  // conversion results
  input wire logic smp_valid,
  input wire sample_t smp,
  output logic smp_ready,
  input wire logic [NCHAN-1:0] chan_enable,
  input wire logic electrode_fmt,
  input wire rate_t rate,
  input wire logic frame_mode,
  output logic range_err,
  // lead-off measurement
  input wire logic loff_valid,
  input wire logic [15:0] loff_value,
  output logic lead_off,
  // pace limits
  input wire logic [7:0] pace_amplitude_limit,
  output logic [8*NPACE-1:0] pace_edge_eff,
  output logic [8*NPACE-1:0] pace_level,
  // channel words
  output logic out_valid,
  output out_item_t out_item,
  input wire logic out_ready
);
  if (NCHAN != 5) begin : g_bad_chan
    $error("channel addresses cover exactly five channels");
  end
  if (NPACE != 3) begin : g_bad_pace
    $error("pace limit registers hold exactly three lanes");
  end

  // ****************************************
  // configuration registers
  // ****************************************
  logic [19:0] loff_upper_r;
  logic [19:0] loff_lower_r;
  logic [23:0] pace_edge_r;
  logic [23:0] pace_level_r;
  logic [3:0] adc_high_margin;
  logic [3:0] adc_low_margin;
  logic [15:0] lead_off_upper_limit;
  logic [15:0] lead_off_lower_limit;

  assign adc_high_margin = loff_upper_r[`MARGIN_HI:`MARGIN_LO];
  assign adc_low_margin = loff_lower_r[`MARGIN_HI:`MARGIN_LO];
  assign lead_off_upper_limit = loff_upper_r[`LIMIT_HI:`LIMIT_LO];
  assign lead_off_lower_limit = loff_lower_r[`LIMIT_HI:`LIMIT_LO];

  // reserved top nibble is dropped, so a careless host write cannot
  // disturb the margins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      loff_upper_r <= `RST_LOFF_UPPER;
      loff_lower_r <= `RST_LOFF_LOWER;
      pace_edge_r <= `RST_PACE;
      pace_level_r <= `RST_PACE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `OFS_LOFF_UPPER: loff_upper_r <= reg_wdata[19:0];
        `OFS_LOFF_LOWER: loff_lower_r <= reg_wdata[19:0];
        `OFS_PACE_EDGE: pace_edge_r <= reg_wdata;
        `OFS_PACE_LEVEL: pace_level_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // range limits
  // ****************************************
  logic [23:0] over_thr;
  logic [23:0] under_thr;
  logic acc;
  logic chan_ok;
  logic over_hit;
  logic under_hit;

  // margin zero gives the extreme code itself, which no sample can pass
  assign over_thr = `CODE_MAX - {14'h0000, adc_high_margin, 6'h00};
  assign under_thr = `CODE_MIN + {14'h0000, adc_low_margin, 6'h00};
  assign chan_ok = (smp.chan < 3'd5) && chan_enable[smp.chan];
  assign acc = smp_valid && smp_ready;
  assign over_hit = smp.code > over_thr;
  assign under_hit = smp.code < under_thr;

  // every accepted enabled result is checked, one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) range_err <= 1'b0;
    else range_err <= acc && chan_ok && (over_hit || under_hit);
  end

  // ****************************************
  // lead-off comparison
  // ****************************************
  // result holds until the next measurement
  always_ff @(posedge core_clk) begin
    if (!rst_n) lead_off <= 1'b0;
    else if (loff_valid) begin
      lead_off <= (loff_value >= lead_off_upper_limit)
        || (loff_value <= lead_off_lower_limit);
    end
  end

  // ****************************************
  // pace limits
  // ****************************************
  logic [7:0] amp_half;
  assign amp_half = {1'b0, pace_amplitude_limit[7:1]};

  for (genvar i = 0; i < NPACE; i++) begin : g_pace
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        pace_edge_eff[8*i +: 8] <= 8'h00;
      end else begin
        pace_edge_eff[8*i +: 8] <= (pace_edge_r[8*i +: 8] == 8'h00) ?
          amp_half : pace_edge_r[8*i +: 8];
      end
    end
  end

  // lanes leave as signed bytes, 0xFF is one step down
  always_ff @(posedge core_clk) begin
    if (!rst_n) pace_level <= '0;
    else pace_level <= pace_level_r;
  end

  // ****************************************
  // channel word packing
  // ****************************************
  chan_word_t word_in;
  logic [23:0] data_full;
  logic half_in;

  always_comb begin
    // electrode: raw unsigned code; lead: signed, doubled LSB
    data_full = electrode_fmt ? smp.code : smp.lead[24:1];
    word_in.addr = `OFS_CHAN_FIRST + {5'h00, smp.chan};
    // left justified; fast rate keeps only 16 significant bits
    word_in.data = (rate == RATE_128K) ? (data_full & `FAST_RATE_MASK) : data_full;
  end

  assign half_in = frame_mode && (rate == RATE_128K);

  // ****************************************
  // output buffer
  // ****************************************
  // a stalled receiver back-pressures the sample source through smp_ready
  word_buffer #(
    .W($bits(out_item_t))
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(smp_valid && chan_ok),
    .in_data({half_in, word_in}),
    .in_ready(smp_ready),
    .out_valid(out_valid),
    .out_data(out_item),
    .out_ready(out_ready)
  );

  // ****************************************
  // last word per channel and register reads
  // ****************************************
  chan_word_t chan_mem [NCHAN];
  logic rd_chan;
  logic [2:0] rd_idx;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NCHAN; k++) chan_mem[k] <= '0;
    end else if (acc && chan_ok) begin
      chan_mem[smp.chan] <= word_in;
    end
  end

  assign rd_chan = (reg_addr >= `OFS_CHAN_FIRST) && (reg_addr <= `OFS_CHAN_LAST);
  assign rd_idx = 3'(reg_addr - `OFS_CHAN_FIRST);

  // register reads always return the full 32-bit word
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (rd_chan) reg_rdata <= chan_mem[rd_idx];
        else begin
          unique case (reg_addr)
            `OFS_LOFF_UPPER: reg_rdata <= {12'h000, loff_upper_r};
            `OFS_LOFF_LOWER: reg_rdata <= {12'h000, loff_lower_r};
            `OFS_PACE_EDGE: reg_rdata <= {8'h00, pace_edge_r};
            `OFS_PACE_LEVEL: reg_rdata <= {8'h00, pace_level_r};
            default: reg_rdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic [7:0] edge1_prev;
  always_ff @(posedge core_clk) begin
    if (!rst_n) edge1_prev <= 8'h00;
    else edge1_prev <= pace_edge_r[7:0];
  end

  property p_over_flag;
    acc && chan_ok && over_hit |=> range_err;
  endproperty
  a_over_flag: assert property (p_over_flag) else $error("high range error missed");

  property p_over_off;
    acc && chan_ok && adc_high_margin == 4'h0 && !under_hit |=> !range_err;
  endproperty
  a_over_off: assert property (p_over_off) else $error("high error with zero margin");

  property p_under_flag;
    acc && chan_ok && under_hit |=> range_err;
  endproperty
  a_under_flag: assert property (p_under_flag) else $error("low range error missed");

  property p_under_off;
    acc && chan_ok && adc_low_margin == 4'h0 && !over_hit |=> !range_err;
  endproperty
  a_under_off: assert property (p_under_off) else $error("low error with zero margin");

  property p_loff_hi;
    loff_valid && loff_value >= lead_off_upper_limit |=> lead_off;
  endproperty
  a_loff_hi: assert property (p_loff_hi) else $error("upper lead-off missed");

  property p_loff_lo;
    loff_valid && loff_value <= lead_off_lower_limit |=> lead_off;
  endproperty
  a_loff_lo: assert property (p_loff_lo) else $error("lower lead-off missed");

  property p_loff_in;
    loff_valid && loff_value < lead_off_upper_limit && loff_value > lead_off_lower_limit
      |=> !lead_off ##1 (lead_off == $past(lead_off) || $past(loff_valid));
  endproperty
  a_loff_in: assert property (p_loff_in) else $error("lead-off without cause");

  property p_edge_half;
    $past(rst_n) && edge1_prev == 8'h00
      |-> pace_edge_eff[7:0] == {1'b0, $past(pace_amplitude_limit[7:1])};
  endproperty
  a_edge_half: assert property (p_edge_half) else $error("zero edge limit not half");

  property p_addr;
    out_valid |-> out_item.word.addr >= `OFS_CHAN_FIRST && out_item.word.addr <= `OFS_CHAN_LAST;
  endproperty
  a_addr: assert property (p_addr) else $error("channel word address out of range");

  property p_fast16;
    acc && chan_ok && rate == RATE_128K |=> chan_mem[$past(smp.chan)].data[7:0] == 8'h00;
  endproperty
  a_fast16: assert property (p_fast16) else $error("fast rate kept low bits");

  property p_lead_fmt;
    acc && chan_ok && !electrode_fmt && rate != RATE_128K
      |=> chan_mem[$past(smp.chan)].data == $past(smp.lead[24:1]);
  endproperty
  a_lead_fmt: assert property (p_lead_fmt) else $error("lead word not halved");

  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_item);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");

  property p_elec_fmt;
    acc && chan_ok && electrode_fmt && rate != RATE_128K
      |=> chan_mem[$past(smp.chan)].data == $past(smp.code);
  endproperty
  a_elec_fmt: assert property (p_elec_fmt) else $error("electrode word not raw code");

  property p_lead_sign;
    acc && chan_ok && !electrode_fmt
      |=> chan_mem[$past(smp.chan)].data[23] == $past(smp.lead[24]);
  endproperty
  a_lead_sign: assert property (p_lead_sign) else $error("lead word lost its sign");

  property p_word_addr;
    acc && chan_ok && !out_valid |=> out_item.word.addr == `OFS_CHAN_FIRST + {5'h00, $past(smp.chan)};
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("word address not channel");

  property p_half_flag;
    acc && chan_ok && !out_valid |=> out_valid && out_item.half == $past(frame_mode && rate == RATE_128K);
  endproperty
  a_half_flag: assert property (p_half_flag) else $error("half flag wrong");

  property p_edge_step;
    $past(rst_n) && edge1_prev != 8'h00 |-> pace_edge_eff[7:0] == edge1_prev;
  endproperty
  a_edge_step: assert property (p_edge_step) else $error("nonzero edge limit altered");

  property p_chan_read;
    reg_rd && rd_chan |=> reg_rvalid && reg_rdata == $past(chan_mem[rd_idx]);
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("channel read not full word");

  property p_rd_pulse;
    !reg_rd |=> !reg_rvalid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer without request");

  property p_range_quiet;
    !(acc && chan_ok) |=> !range_err;
  endproperty
  a_range_quiet: assert property (p_range_quiet) else $error("range error without sample");

  property p_loff_hold;
    !loff_valid |=> $stable(lead_off);
  endproperty
  a_loff_hold: assert property (p_loff_hold) else $error("lead-off moved between measurements");

  property p_ready_full;
    $past(rst_n) && !smp_ready |-> out_valid;
  endproperty
  a_ready_full: assert property (p_ready_full) else $error("refused sample while buffer empty");

  c_range: cover property (acc && chan_ok ##1 range_err);
  c_loff: cover property (loff_valid ##1 lead_off);
  c_stall: cover property (out_valid && !out_ready [*2] ##1 !smp_ready);
  c_read: cover property (reg_rd && rd_chan ##1 reg_rvalid);
endmodule : ecg_threshold_core

// File: core/ecg_consts.svh
// constants of the channel threshold and data-word block
// assumes inclusion by bare name from the core module and the testbench
// Operation
// - A conversion above full scale minus the high margin times 64 raises a range error.
// - A high margin of zero puts the limit at the top code, so no high error can occur.
// - A conversion below the bottom code plus the low margin times 64 raises a range error.
// - A low margin of zero puts the limit at the bottom code, so no low error can occur.
// - Lead-off is declared when the ac lead-off value is at or above the upper limit.
// - Lead-off is declared when the ac lead-off value is at or below the lower limit.
// - Three 8-bit pace edge limits exist; zero means half the pace amplitude limit.
// - The three pace level limits are signed two's complement steps.
// - Each channel word carries its address 0x11 to 0x15 in the top byte.
// - Sample data is left justified in the 24-bit field at every data rate.
// - Electrode format samples are unsigned, zero code at zero volts.
// - Lead format samples are signed two's complement.
// - Lead format uses a doubled LSB weight relative to electrode format.
// - Sixteen significant bits at the fastest rate, twenty-four at the slower rates.
// - At the fastest rate in frame mode only the upper 16 bits of a word are sent.
`ifndef ECG_CONSTS_SVH
`define ECG_CONSTS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_LOFF_UPPER 8'h0C
`define OFS_LOFF_LOWER 8'h0D
`define OFS_PACE_EDGE 8'h0E
`define OFS_PACE_LEVEL 8'h0F
`define OFS_CHAN_FIRST 8'h11
`define OFS_CHAN_LAST 8'h15

// ****************************************
// fields and reset values
// ****************************************
`define MARGIN_HI 19
`define MARGIN_LO 16
`define LIMIT_HI 15
`define LIMIT_LO 0
`define MARGIN_SHIFT 6
`define RST_LOFF_UPPER 20'h0FFFF
`define RST_LOFF_LOWER 20'h00000
`define RST_PACE 24'h000000
`define CODE_MAX 24'hFFFFFF
`define CODE_MIN 24'h000000
`define FAST_RATE_MASK 24'hFFFF00

`endif

// File: core/ecg_pkg.sv
// types shared by the threshold block, its word sink and its testbench
// assumes ecg_consts.svh is on the include path
package ecg_pkg;
  typedef enum logic [1:0] {RATE_2K, RATE_16K, RATE_128K, RATE_SLOW} rate_t;

  typedef struct packed {
    logic [2:0] chan;
    logic [23:0] code;
    logic signed [24:0] lead;
  } sample_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [23:0] data;
  } chan_word_t;

  typedef struct packed {
    logic half;
    chan_word_t word;
  } out_item_t;
endpackage : ecg_pkg

// File: core/word_buffer.sv
// two-entry buffer with valid and ready on both sides
// assumes a single clock and synchronous active-low reset
`timescale 1ns/100ps
module word_buffer #(
  parameter int W = 33
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] tail_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic push;
  logic pop;

  if (W < 1) begin : g_bad_width
    $error("word_buffer width must be positive");
  end

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) cnt_nxt = cnt_r + 2'd1;
    else if (pop && !push) cnt_nxt = cnt_r - 2'd1;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_r <= 2'd0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_valid <= (cnt_nxt != 2'd0);
      in_ready <= (cnt_nxt != 2'd2);
    end
  end

  // head moves up from the tail on a pop, new word lands in the free slot
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_data <= '0;
      tail_r <= '0;
    end else begin
      if (pop) out_data <= (cnt_r == 2'd2) ? tail_r : in_data;
      else if (push && cnt_r == 2'd0) out_data <= in_data;
      if (push && ((cnt_r == 2'd1 && !pop) || (cnt_r == 2'd2 && pop))) tail_r <= in_data;
    end
  end
endmodule : word_buffer

// File: testbench/word_sink.sv
// receiving side of the channel word stream, with a stall control
// assumes the block's core_clk and rst_n; ready moves on the falling edge
`timescale 1ns/100ps
module word_sink
  import ecg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // word stream
  input wire logic out_valid,
  input wire out_item_t out_item,
  output logic out_ready,
  // control
  input wire logic stall
);
  out_item_t got[$];
  initial out_ready = 1'b0;
  // ready stays off the sampling edge so a take never races the head
  always @(negedge core_clk) begin
    out_ready <= !stall;
  end
  always @(posedge core_clk) begin
    if (rst_n && out_valid && out_ready) begin
      got.push_back(out_item);
    end
  end
endmodule : word_sink

// File: testbench/test_ecg_threshold_core.sv
// self-checking bench of the threshold and channel word block
// assumes ecg_consts.svh on the include path and word_sink as the receiver
`timescale 1ns/100ps
`include "ecg_consts.svh"
module test_ecg_threshold_core;
  import ecg_pkg::*;
  typedef struct packed {
    logic ef; rate_t rt; logic fm; logic [2:0] ch; logic [23:0] code;
    logic [24:0] lead; logic [3:0] hi; logic [3:0] lo; logic err;
    logic [23:0] data; logic half;
  } row_t;
  localparam int NROW = 16;
  row_t rows [NROW] = '{
    '{1, RATE_2K, 0, 0, 24'h123456, 25'h0, 4'h0, 4'h0, 0, 24'h123456, 0},
    '{1, RATE_2K, 0, 1, 24'hFFFFFF, 25'h0, 4'h0, 4'h0, 0, 24'hFFFFFF, 0},
    '{1, RATE_2K, 0, 2, 24'h000000, 25'h0, 4'h0, 4'h0, 0, 24'h000000, 0},
    '{1, RATE_2K, 0, 3, 24'hFFFFBF, 25'h0, 4'h1, 4'h0, 0, 24'hFFFFBF, 0},
    '{1, RATE_2K, 0, 4, 24'hFFFFC0, 25'h0, 4'h1, 4'h0, 1, 24'hFFFFC0, 0},
    '{1, RATE_2K, 0, 0, 24'hFFFC40, 25'h0, 4'hF, 4'h0, 1, 24'hFFFC40, 0},
    '{1, RATE_2K, 0, 1, 24'hFFFC3F, 25'h0, 4'hF, 4'h0, 0, 24'hFFFC3F, 0},
    '{1, RATE_2K, 0, 2, 24'h00003F, 25'h0, 4'h0, 4'h1, 1, 24'h00003F, 0},
    '{1, RATE_2K, 0, 3, 24'h000040, 25'h0, 4'h0, 4'h1, 0, 24'h000040, 0},
    '{1, RATE_2K, 0, 4, 24'h0003BF, 25'h0, 4'h0, 4'hF, 1, 24'h0003BF, 0},
    '{0, RATE_16K, 0, 0, 24'h800000, 25'h1FFFFFE, 4'h0, 4'h0, 0, 24'hFFFFFF, 0},
    '{0, RATE_2K, 0, 1, 24'h800000, 25'h1000000, 4'h0, 4'h0, 0, 24'h800000, 0},
    '{0, RATE_16K, 0, 2, 24'h800000, 25'h0ABCDEF, 4'h0, 4'h0, 0, 24'h55E6F7, 0},
    '{1, RATE_128K, 1, 3, 24'hABCDEF, 25'h0, 4'h0, 4'h0, 0, 24'hABCD00, 1},
    '{1, RATE_128K, 0, 4, 24'hABCDEF, 25'h0, 4'h0, 4'h0, 0, 24'hABCD00, 0},
    '{1, RATE_SLOW, 1, 0, 24'hABCDEF, 25'h0, 4'h0, 4'h0, 0, 24'hABCDEF, 0}};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic smp_valid = 1'b0;
  sample_t smp = '0;
  logic smp_ready;
  logic [4:0] chan_enable = 5'h1F;
  logic electrode_fmt = 1'b1;
  rate_t rate = RATE_2K;
  logic frame_mode = 1'b0;
  logic range_err;
  logic loff_valid = 1'b0;
  logic [15:0] loff_value = 16'h0000;
  logic lead_off;
  logic [7:0] pace_amplitude_limit = 8'h40;
  logic [23:0] pace_edge_eff;
  logic [23:0] pace_level;
  logic out_valid;
  out_item_t out_item;
  logic out_ready;
  logic stall = 1'b0;
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  logic err_seen;
  ecg_threshold_core uut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .smp_valid(smp_valid), .smp(smp), .smp_ready(smp_ready),
    .chan_enable(chan_enable), .electrode_fmt(electrode_fmt), .rate(rate),
    .frame_mode(frame_mode), .range_err(range_err), .loff_valid(loff_valid),
    .loff_value(loff_value), .lead_off(lead_off),
    .pace_amplitude_limit(pace_amplitude_limit), .pace_edge_eff(pace_edge_eff),
    .pace_level(pace_level), .out_valid(out_valid), .out_item(out_item),
    .out_ready(out_ready));
  word_sink sink (.core_clk(core_clk), .rst_n(rst_n), .out_valid(out_valid),
    .out_item(out_item), .out_ready(out_ready), .stall(stall));
  always #2.5 core_clk = ~core_clk;
  // ****************************************
  // helpers
  // ****************************************
  task automatic final_report();
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check({reg_rvalid, reg_rdata}, {1'b1, exp});
  endtask : rd
  task automatic send(input logic [2:0] ch, input logic [23:0] c, input logic [24:0] l);
    int n;
    @(negedge core_clk);
    smp_valid = 1'b1;
    smp = '{chan: ch, code: c, lead: l};
    for (n = 0; n < 20 && smp_ready !== 1'b1; n++) @(negedge core_clk);
    @(negedge core_clk);
    err_seen = range_err;
    smp_valid = 1'b0;
  endtask : send
  task automatic take(input logic [32:0] exp);
    int n;
    for (n = 0; n < 20 && sink.got.size() == 0; n++) @(negedge core_clk);
    check(sink.got.size() > 0 ? sink.got.pop_front() : 33'bx, exp);
  endtask : take
  task automatic loff(input logic [15:0] v, input logic exp);
    @(negedge core_clk);
    loff_valid = 1'b1;
    loff_value = v;
    @(negedge core_clk);
    loff_valid = 1'b0;
    check(lead_off, exp);
  endtask : loff
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      final_report();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      wr(`OFS_LOFF_UPPER, {4'h0, rows[i].hi, 16'hFFFF});
      wr(`OFS_LOFF_LOWER, {4'h0, rows[i].lo, 16'h0000});
      electrode_fmt = rows[i].ef;
      rate = rows[i].rt;
      frame_mode = rows[i].fm;
      send(rows[i].ch, rows[i].code, rows[i].lead);
      check(err_seen, rows[i].err);
      take({rows[i].half, 8'h11 + rows[i].ch, rows[i].data});
    end
    rd(`OFS_CHAN_FIRST, 32'h11ABCDEF);
    rd(8'h14, 32'h14ABCD00);
    // disabled channel and out-of-map channel give no word and no error
    wr(`OFS_LOFF_UPPER, 24'h01FFFF);
    chan_enable = 5'h0F;
    send(3'd4, 24'hFFFFFF, 25'h0);
    check(err_seen, 1'b0);
    send(3'd5, 24'h000001, 25'h0);
    repeat (4) @(negedge core_clk);
    check(sink.got.size(), 33'd0);
    // two words held while the receiver stalls, none lost
    chan_enable = 5'h1F;
    stall = 1'b1;
    send(3'd1, 24'h000100, 25'h0);
    send(3'd2, 24'h000200, 25'h0);
    @(negedge core_clk);
    check(smp_ready, 1'b0);
    stall = 1'b0;
    take({1'b0, 8'h12, 24'h000100});
    take({1'b0, 8'h13, 24'h000200});
    // lead-off limits, default then programmed
    loff(16'h0000, 1'b1);
    loff(16'h8000, 1'b0);
    loff(16'hFFFF, 1'b1);
    wr(`OFS_LOFF_UPPER, 24'h001000);
    wr(`OFS_LOFF_LOWER, 24'h000100);
    loff(16'h1000, 1'b1);
    loff(16'h0FFF, 1'b0);
    loff(16'h0100, 1'b1);
    loff(16'h0101, 1'b0);
    // pace limits: a zero edge lane falls back to half the amplitude limit
    wr(`OFS_PACE_EDGE, 24'h030005);
    wr(`OFS_PACE_LEVEL, 24'hFF017F);
    pace_amplitude_limit = 8'h41;
    repeat (2) @(negedge core_clk);
    check(pace_edge_eff, 33'h032005);
    check(pace_level, 33'hFF017F);
    rd(`OFS_PACE_EDGE, 32'h00030005);
    rd(`OFS_PACE_LEVEL, 32'h00FF017F);
    rd(8'h20, 32'h00000000);
    // second reset in mid-run restores the register defaults
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    rd(`OFS_LOFF_UPPER, 32'h0000FFFF);
    rd(`OFS_LOFF_LOWER, 32'h00000000);
    rd(`OFS_PACE_EDGE, 32'h00000000);
    rd(`OFS_PACE_LEVEL, 32'h00000000);
    rd(`OFS_CHAN_LAST, 32'h00000000);
    check(pace_edge_eff, 33'h202020);
    final_report();
  end
endmodule : test_ecg_threshold_core
